// ### src/dis_pkg.sv
// constants shared by the interrupt source block and its testbench
package dis_pkg;

    // ------------------------------------------------------------------
    // register port geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_ENABLE  = 8'h00;  // per-source enable, read/write
    localparam logic [7:0] OFS_PENDING = 8'h04;  // sticky flags, write one to clear
    localparam logic [7:0] OFS_ACTIVE  = 8'h08;  // enabled pending flags and line state
    localparam logic [7:0] OFS_LEVELS  = 8'h0c;  // live source conditions

    // ------------------------------------------------------------------
    // interrupt source numbering
    // ------------------------------------------------------------------
    localparam int NUM_SRC          = 12;
    localparam int SRC_ACQ_RUNNING  = 0;   // acq_running_irq
    localparam int SRC_ACQ_STOP     = 1;   // acq_stop_seen_irq
    localparam int SRC_ACQ_COMPLETE = 2;   // acq_complete_irq
    localparam int SRC_IN_QUARTER   = 3;   // in_fifo_quarter_irq
    localparam int SRC_PER_CONV     = 4;   // per_conversion_irq
    localparam int SRC_END_SCAN     = 5;   // end_of_scan_irq
    localparam int SRC_END_INTERVAL = 6;   // end_of_interval_irq
    localparam int SRC_OUT_RUNNING  = 7;   // output waveform running
    localparam int SRC_OUT_COMPLETE = 8;   // output waveform sequence complete
    localparam int SRC_OUT_QUARTER  = 9;   // output fifo drained a quarter
    localparam int SRC_HIGH_CHAN    = 10;  // highest output channel updated
    localparam int SRC_SPARE        = 11;  // spare source, never set

    // ------------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [11:0] ENABLE_RST = 12'h000;
    localparam int          LINE_BIT   = 31;   // line state in the active register

    // ------------------------------------------------------------------
    // fifo and channel geometry
    // ------------------------------------------------------------------
    localparam int          IN_CNT_W          = 15;
    localparam logic [14:0] IN_FIFO_DEPTH     = 15'h4000;
    localparam logic [14:0] IN_QUARTER_FILL   = 15'h1000;  // depth / 4
    localparam int          OUT_CNT_W         = 15;
    localparam logic [14:0] OUT_FIFO_DEPTH    = 15'h4000;
    localparam logic [14:0] OUT_QUARTER_EMPTY = 15'h3000;  // depth * 3 / 4 still held
    localparam int          AI_CHAN_W         = 4;
    localparam int          AO_CHAN_W         = 1;
    localparam logic [0:0] AO_HIGH_CHAN       = 1'h1;

endpackage : dis_pkg

// ### src/dis_irq_flag.sv
// one sticky pending flag with its enable gate
`timescale 1ns/1ns
`default_nettype none

module dis_irq_flag (
    input  wire logic clock_i,
    input  wire logic resetn_i,
    input  wire logic ce_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    input  wire logic en_i,
    output logic      pend_o,
    output logic      req_o
);

    logic pend_r;
    logic pend_nxt;

    // ------------------------------------------------------------------
    // flag update
    // ------------------------------------------------------------------

    // a set in the clearing cycle survives the clear
    assign pend_nxt = set_i | (pend_r & ~clr_i);

    // state only moves while the clock enable is high
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            pend_r <= 1'b0;
        end else if (ce_i) begin
            pend_r <= pend_nxt;
        end
    end

    // the request reaches the line only through the enable
    assign pend_o = pend_r;
    assign req_o  = pend_r & en_i;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_set_wins_clear: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (ce_i && set_i && clr_i) |=> pend_r)
        else $error("flag lost a set that met a clear");

endmodule // dis_irq_flag

`default_nettype wire

// ### src/dis_top.sv
// interrupt source collection, pending flags and interrupt line
//
// Summary of operation
// - every enabled pending interrupt drives the shared active-low bus line
// - acquisition running sets its flag every cycle the sequence is active
// - a rising edge on the acquisition stop trigger pin sets its flag
// - the acquisition done pulse sets the acquisition complete flag
// - input fifo filling to one quarter of capacity sets its flag
// - every completed conversion sets the per conversion flag
// - in multi channel scans, converting the last channel sets end of scan
// - in multi channel scans, each elapsed interval delay sets its flag
// - output waveform running sets its flag every cycle it is active
// - the output done pulse sets the output complete flag
// - output fifo draining to one quarter empty sets its flag
// - each update of the highest output channel sets its flag
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module dis_top (
    input  wire logic                          clock_i,
    input  wire logic                          resetn_i,
    input  wire logic                          ce_i,
    // register port
    input  wire logic [dis_pkg::ADDR_W-1:0]    reg_addr_i,
    input  wire logic [dis_pkg::DATA_W-1:0]    reg_wdata_i,
    input  wire logic                          reg_wr_i,
    input  wire logic                          reg_rd_i,
    output logic      [dis_pkg::DATA_W-1:0]    reg_rdata_o,
    // acquisition sequencer and input fifo
    input  wire logic                          acq_active_i,
    input  wire logic                          acq_stop_trig_pin_i,
    input  wire logic                          acq_done_i,
    input  wire logic [dis_pkg::IN_CNT_W-1:0]  in_fifo_count_i,
    input  wire logic                          conv_done_i,
    input  wire logic [dis_pkg::AI_CHAN_W-1:0] conv_chan_i,
    input  wire logic [dis_pkg::AI_CHAN_W-1:0] scan_last_chan_i,
    input  wire logic                          multi_scan_i,
    input  wire logic                          interval_done_i,
    // waveform engine and output fifo
    input  wire logic                          ao_active_i,
    input  wire logic                          ao_done_i,
    input  wire logic [dis_pkg::OUT_CNT_W-1:0] out_fifo_count_i,
    input  wire logic                          ao_update_i,
    input  wire logic [dis_pkg::AO_CHAN_W-1:0] ao_chan_i,
    // interrupt line toward the bus bridge
    output logic                               inta_n_o
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [dis_pkg::NUM_SRC-1:0] enable_r;
    logic [dis_pkg::NUM_SRC-1:0] enable_nxt;
    logic [dis_pkg::NUM_SRC-1:0] pend;
    logic [dis_pkg::NUM_SRC-1:0] req;
    logic [dis_pkg::NUM_SRC-1:0] set_vec;
    logic [dis_pkg::NUM_SRC-1:0] clr_vec;
    logic [dis_pkg::DATA_W-1:0]  rdata_r;
    logic [dis_pkg::DATA_W-1:0]  rdata_nxt;
    logic                        irq_n_r;
    logic                        any_req;
    logic                        stop_s1_r;
    logic                        stop_s2_r;
    logic                        stop_s3_r;
    logic                        stop_edge;
    logic                        in_q_lvl;
    logic                        in_q_prev_r;
    logic                        in_q_rise;
    logic                        out_q_lvl;
    logic                        out_q_prev_r;
    logic                        out_q_rise;
    logic                        last_chan_hit;
    logic                        high_chan_hit;
    logic                        sel_enable;
    logic                        sel_pending;
    logic                        sel_active;
    logic                        sel_levels;
    logic                        wr_enable;
    logic                        wr_pending;
    logic [dis_pkg::DATA_W-1:0]  enable_word;
    logic [dis_pkg::DATA_W-1:0]  pending_word;
    logic [dis_pkg::DATA_W-1:0]  active_word;
    logic [dis_pkg::DATA_W-1:0]  levels_word;

    // ------------------------------------------------------------------
    // stop trigger pin synchroniser and edge detector
    // ------------------------------------------------------------------

    // the pin is asynchronous: two stages before anything looks at it
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            stop_s1_r <= 1'b0;
            stop_s2_r <= 1'b0;
            stop_s3_r <= 1'b0;
        end else if (ce_i) begin
            stop_s1_r <= acq_stop_trig_pin_i;
            stop_s2_r <= stop_s1_r;
            stop_s3_r <= stop_s2_r;
        end
    end

    // edge taken between the second and third stage only
    assign stop_edge = stop_s2_r & ~stop_s3_r;

    // ------------------------------------------------------------------
    // fifo threshold crossings
    // ------------------------------------------------------------------

    // input fifo at or above a quarter of capacity
    assign in_q_lvl   = (in_fifo_count_i >= dis_pkg::IN_QUARTER_FILL);
    assign in_q_rise  = in_q_lvl & ~in_q_prev_r;
    // output fifo holding no more than three quarters: a quarter empty
    assign out_q_lvl  = (out_fifo_count_i <= dis_pkg::OUT_QUARTER_EMPTY);
    assign out_q_rise = out_q_lvl & ~out_q_prev_r;

    // previous threshold levels, so each crossing raises one event
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            in_q_prev_r  <= 1'b0;
            out_q_prev_r <= 1'b1;  // an empty fifo after reset is not a crossing
        end else if (ce_i) begin
            in_q_prev_r  <= in_q_lvl;
            out_q_prev_r <= out_q_lvl;
        end
    end

    // ------------------------------------------------------------------
    // scan and channel qualifiers
    // ------------------------------------------------------------------
    assign last_chan_hit = conv_done_i & multi_scan_i &
                           (conv_chan_i == scan_last_chan_i);
    assign high_chan_hit = ao_update_i & (ao_chan_i == dis_pkg::AO_HIGH_CHAN);

    // ------------------------------------------------------------------
    // event vector
    // ------------------------------------------------------------------
    assign set_vec[dis_pkg::SRC_ACQ_RUNNING]  = acq_active_i;
    assign set_vec[dis_pkg::SRC_ACQ_STOP]     = stop_edge;
    assign set_vec[dis_pkg::SRC_ACQ_COMPLETE] = acq_done_i;
    assign set_vec[dis_pkg::SRC_IN_QUARTER]   = in_q_rise;
    assign set_vec[dis_pkg::SRC_PER_CONV]     = conv_done_i;
    assign set_vec[dis_pkg::SRC_END_SCAN]     = last_chan_hit;
    assign set_vec[dis_pkg::SRC_END_INTERVAL] = interval_done_i & multi_scan_i;
    assign set_vec[dis_pkg::SRC_OUT_RUNNING]  = ao_active_i;
    assign set_vec[dis_pkg::SRC_OUT_COMPLETE] = ao_done_i;
    assign set_vec[dis_pkg::SRC_OUT_QUARTER]  = out_q_rise;
    assign set_vec[dis_pkg::SRC_HIGH_CHAN]    = high_chan_hit;
    assign set_vec[dis_pkg::SRC_SPARE]        = 1'b0;

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    assign sel_enable  = (reg_addr_i == dis_pkg::OFS_ENABLE);
    assign sel_pending = (reg_addr_i == dis_pkg::OFS_PENDING);
    assign sel_active  = (reg_addr_i == dis_pkg::OFS_ACTIVE);
    assign sel_levels  = (reg_addr_i == dis_pkg::OFS_LEVELS);
    assign wr_enable   = reg_wr_i & sel_enable;
    assign wr_pending  = reg_wr_i & sel_pending;

    // write-one-to-clear mask for the flags
    assign clr_vec    = wr_pending ? reg_wdata_i[dis_pkg::NUM_SRC-1:0]
                                   : {dis_pkg::NUM_SRC{1'b0}};
    assign enable_nxt = wr_enable ? reg_wdata_i[dis_pkg::NUM_SRC-1:0] : enable_r;

    // enable register
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            enable_r <= dis_pkg::ENABLE_RST;
        end else if (ce_i) begin
            enable_r <= enable_nxt;
        end
    end

    // ------------------------------------------------------------------
    // pending flags, one cell per source
    // ------------------------------------------------------------------
    generate
        for (genvar g = 0; g < dis_pkg::NUM_SRC; g++) begin : g_flag
            dis_irq_flag u_flag (
                .clock_i  (clock_i),
                .resetn_i (resetn_i),
                .ce_i     (ce_i),
                .set_i    (set_vec[g]),
                .clr_i    (clr_vec[g]),
                .en_i     (enable_r[g]),
                .pend_o   (pend[g]),
                .req_o    (req[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // interrupt line
    // ------------------------------------------------------------------
    assign any_req = |req;

    // registered so the line never glitches toward the bridge
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            irq_n_r <= 1'b1;
        end else if (ce_i) begin
            irq_n_r <= ~any_req;
        end
    end

    assign inta_n_o = irq_n_r;

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    assign enable_word  = {{(dis_pkg::DATA_W-dis_pkg::NUM_SRC){1'b0}}, enable_r};
    assign pending_word = {{(dis_pkg::DATA_W-dis_pkg::NUM_SRC){1'b0}}, pend};
    assign active_word  = {~irq_n_r, {(dis_pkg::DATA_W-1-dis_pkg::NUM_SRC){1'b0}}, req};
    assign levels_word  = {27'h0000000, out_q_lvl, in_q_lvl, ao_active_i,
                           stop_s2_r, acq_active_i};

    // unmapped offsets and idle cycles read as zero
    assign rdata_nxt = !reg_rd_i  ? 32'h00000000 :
                       sel_enable  ? enable_word  :
                       sel_pending ? pending_word :
                       sel_active  ? active_word  :
                       sel_levels  ? levels_word  : 32'h00000000;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            rdata_r <= 32'h00000000;
        end else if (ce_i) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);

    chk_line_follows_req: assert property (
        ce_i |=> (inta_n_o == !$past(any_req)))
        else $error("interrupt line does not follow enabled pending flags");

    chk_line_frozen_ce: assert property (
        !ce_i |=> $stable(inta_n_o))
        else $error("interrupt line moved while clock enable low");

    chk_acq_run_set: assert property (
        (ce_i && acq_active_i) |=> pend[dis_pkg::SRC_ACQ_RUNNING])
        else $error("acquisition running flag not set");

    chk_stop_pin_edge: assert property (
        (ce_i && !acq_stop_trig_pin_i) ##1 (ce_i && acq_stop_trig_pin_i) ##1 ce_i [*2]
        |=> pend[dis_pkg::SRC_ACQ_STOP])
        else $error("stop trigger edge not flagged within synchroniser delay");

    chk_done_set: assert property (
        (ce_i && acq_done_i) |=> pend[dis_pkg::SRC_ACQ_COMPLETE])
        else $error("acquisition complete flag not set");

    chk_in_quarter: assert property (
        (ce_i && in_fifo_count_i < dis_pkg::IN_QUARTER_FILL) ##1
        (ce_i && in_fifo_count_i >= dis_pkg::IN_QUARTER_FILL)
        |=> pend[dis_pkg::SRC_IN_QUARTER])
        else $error("input fifo quarter flag not set");

    chk_scan_end: assert property (
        (ce_i && conv_done_i && multi_scan_i && conv_chan_i == scan_last_chan_i)
        |=> pend[dis_pkg::SRC_END_SCAN] && pend[dis_pkg::SRC_PER_CONV])
        else $error("end of scan or conversion flag not set");

    chk_high_chan: assert property (
        (ce_i && ao_update_i && ao_chan_i == dis_pkg::AO_HIGH_CHAN)
        |=> pend[dis_pkg::SRC_HIGH_CHAN])
        else $error("high channel update flag not set");

    chk_w1c_clears: assert property (
        (ce_i && wr_pending && reg_wdata_i[dis_pkg::SRC_ACQ_COMPLETE]
         && !acq_done_i) |=> !pend[dis_pkg::SRC_ACQ_COMPLETE])
        else $error("write one did not clear the flag");

    chk_masked_silent: assert property (
        (ce_i && enable_r == 12'h000) |=> inta_n_o)
        else $error("line asserted with every source disabled");

    chk_read_one_cycle: assert property (
        (ce_i && !reg_rd_i) |=> (reg_rdata_o == 32'h00000000))
        else $error("read data present without a read strobe");

    // register port: a write loads the enables, holes read as zero
    chk_enable_write: assert property (
        (ce_i && wr_enable) |=> (enable_r == $past(reg_wdata_i[dis_pkg::NUM_SRC-1:0])))
        else $error("enable write lost");

    chk_unmapped_zero: assert property (
        (ce_i && reg_rd_i && !sel_enable && !sel_pending && !sel_active && !sel_levels)
        |=> (reg_rdata_o == 32'h00000000))
        else $error("unmapped read not zero");

    chk_flags_frozen: assert property (
        !ce_i |=> ($stable(pend) && $stable(enable_r)))
        else $error("state moved with clock enable low");

    // acquisition sources not checked above
    chk_conv_set: assert property (
        (ce_i && conv_done_i) |=> pend[dis_pkg::SRC_PER_CONV])
        else $error("conversion flag not set");

    chk_interval_set: assert property (
        (ce_i && interval_done_i && multi_scan_i) |=> pend[dis_pkg::SRC_END_INTERVAL])
        else $error("interval flag not set");

    chk_single_scan_quiet: assert property (
        (ce_i && !multi_scan_i && !pend[dis_pkg::SRC_END_SCAN])
        |=> !pend[dis_pkg::SRC_END_SCAN])
        else $error("end of scan set in single scan");

    // output side sources
    chk_ao_run_set: assert property (
        (ce_i && ao_active_i) |=> pend[dis_pkg::SRC_OUT_RUNNING])
        else $error("output running flag not set");

    chk_ao_done_set: assert property (
        (ce_i && ao_done_i) |=> pend[dis_pkg::SRC_OUT_COMPLETE])
        else $error("output complete flag not set");

    chk_out_quarter: assert property (
        (ce_i && out_fifo_count_i > dis_pkg::OUT_QUARTER_EMPTY) ##1
        (ce_i && out_fifo_count_i <= dis_pkg::OUT_QUARTER_EMPTY)
        |=> pend[dis_pkg::SRC_OUT_QUARTER])
        else $error("output quarter flag not set");

    // scenario coverage
    cov_line_asserted: cover property (ce_i && !inta_n_o ##1 ce_i && wr_pending);
    cov_set_meets_clear: cover property (ce_i && |(set_vec & clr_vec));
    cov_stop_seen: cover property (stop_edge && enable_r[dis_pkg::SRC_ACQ_STOP]);
    cov_out_quarter: cover property (ce_i && out_q_rise);
    cov_frozen_write: cover property (!ce_i && reg_wr_i);

endmodule // dis_top

`default_nettype wire

// ### verif/dis_host_model.sv
// host side model: interrupt routing that counts assertions of the shared line
`timescale 1ns/1ns
`default_nettype none

module dis_host_model (
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    input  wire logic       inta_n_i,
    output logic      [7:0] irq_count_o
);
    logic line_q_r;

    // --------------------------------------------------------------
    // interrupt routing
    // --------------------------------------------------------------
    // each fall of the active-low line is one routed system interrupt
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            line_q_r    <= 1'b1;
            irq_count_o <= 8'h00;
        end else begin
            line_q_r <= inta_n_i;
            if (line_q_r && !inta_n_i) begin
                irq_count_o <= irq_count_o + 8'h01;
            end
        end
    end
endmodule // dis_host_model

`default_nettype wire

// ### verif/dis_top_test.sv
// self-checking bench for the interrupt source block
`timescale 1ns/1ns
`default_nettype none

module dis_top_test;
    logic        clock_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic        acq_active = 1'b0;
    logic        stop_pin = 1'b0;
    logic        acq_done = 1'b0;
    logic [14:0] in_cnt = 15'h0000;
    logic        conv_done = 1'b0;
    logic [3:0]  conv_chan = 4'h0;
    logic [3:0]  last_chan = 4'h3;
    logic        multi = 1'b1;
    logic        interval_done = 1'b0;
    logic        ao_active = 1'b0;
    logic        ao_done = 1'b0;
    logic [14:0] out_cnt = 15'h0000;
    logic        ao_update = 1'b0;
    logic [0:0]  ao_chan = 1'h0;
    logic        inta_n;
    logic [7:0]  irq_count;
    int          n_mismatch = 0;
    int          cmp_count = 0;

    // --------------------------------------------------------------
    // clock, design and host model
    // --------------------------------------------------------------
    always #4 clock_i = ~clock_i;

    dis_top dut (.clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .acq_active_i(acq_active), .acq_stop_trig_pin_i(stop_pin), .acq_done_i(acq_done),
        .in_fifo_count_i(in_cnt), .conv_done_i(conv_done), .conv_chan_i(conv_chan),
        .scan_last_chan_i(last_chan), .multi_scan_i(multi), .interval_done_i(interval_done),
        .ao_active_i(ao_active), .ao_done_i(ao_done), .out_fifo_count_i(out_cnt),
        .ao_update_i(ao_update), .ao_chan_i(ao_chan), .inta_n_o(inta_n));

    dis_host_model host (.clock_i(clock_i), .resetn_i(resetn_i), .inta_n_i(inta_n),
        .irq_count_o(irq_count));

    // --------------------------------------------------------------
    // reporting and bus tasks
    // --------------------------------------------------------------
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock_i);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // drive one source for one cycle, then let flag and line settle
    task automatic fire(input int s);
        @(posedge clock_i);
        case (s)
            0: acq_active <= 1'b1;
            1: stop_pin <= 1'b1;
            2: acq_done <= 1'b1;
            3: in_cnt <= 15'h1000;
            4: begin conv_chan <= 4'h0; conv_done <= 1'b1; end
            5: begin conv_chan <= 4'h3; conv_done <= 1'b1; end
            6: interval_done <= 1'b1;
            7: ao_active <= 1'b1;
            8: ao_done <= 1'b1;
            9: out_cnt <= 15'h3001;
            10: begin ao_chan <= 1'h1; ao_update <= 1'b1; end
            default: ;
        endcase
        @(posedge clock_i);
        {acq_active, stop_pin, acq_done, conv_done} <= 4'h0;
        {interval_done, ao_active, ao_done, ao_update} <= 4'h0;
        if (s == 9) out_cnt <= 15'h3000;
        repeat (5) @(posedge clock_i);
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] v;
        rd_reg(dis_pkg::OFS_ENABLE, v);
        chk("enable", 32'h0, v);
        rd_reg(dis_pkg::OFS_PENDING, v);
        chk("pending", 32'h0, v);
        rd_reg(8'h10, v);
        chk("unmapped", 32'h0, v);
        chk("line", 32'h1, {31'h0, inta_n});
        $display("test reset done");
    endtask

    task automatic t_sources();
        logic [31:0] v;
        logic [31:0] exp;
        wr_reg(dis_pkg::OFS_ENABLE, 32'h00000fff);
        rd_reg(dis_pkg::OFS_ENABLE, v);
        chk("enable", 32'h00000fff, v);
        for (int s = 0; s < 11; s++) begin
            exp = (s == 5) ? 32'h30 : (32'h1 << s);
            fire(s);
            rd_reg(dis_pkg::OFS_PENDING, v);
            chk("pending", exp, v);
            chk("line", 32'h0, {31'h0, inta_n});
            chk("host count", s + 1, {24'h0, irq_count});
            wr_reg(dis_pkg::OFS_PENDING, 32'h00000fff);
            repeat (2) @(posedge clock_i);
            rd_reg(dis_pkg::OFS_PENDING, v);
            chk("cleared", 32'h0, v);
            chk("line", 32'h1, {31'h0, inta_n});
        end
        $display("test sources done");
    endtask

    task automatic t_refuse();
        logic [31:0] v;
        @(posedge clock_i);
        multi <= 1'b0;
        fire(6);
        fire(5);
        rd_reg(dis_pkg::OFS_PENDING, v);
        chk("single scan", 32'h10, v);
        wr_reg(dis_pkg::OFS_PENDING, 32'h00000fff);
        multi <= 1'b1;
        $display("test refuse done");
    endtask

    task automatic t_mask();
        logic [31:0] v;
        int          k;
        wr_reg(dis_pkg::OFS_ENABLE, 32'h00000ffb);
        fire(2);
        chk("line masked", 32'h1, {31'h0, inta_n});
        rd_reg(dis_pkg::OFS_ACTIVE, v);
        chk("active", 32'h0, v);
        wr_reg(dis_pkg::OFS_ENABLE, 32'h00000004);
        k = 0;
        while (inta_n !== 1'b0 && k < 8) begin
            @(posedge clock_i);
            k++;
        end
        if (k == 8) begin
            n_mismatch++;
            final_report();
        end
        rd_reg(dis_pkg::OFS_ACTIVE, v);
        chk("active", 32'h80000004, v);
        wr_reg(dis_pkg::OFS_ENABLE, 32'h0);
        repeat (2) @(posedge clock_i);
        chk("line off", 32'h1, {31'h0, inta_n});
        rd_reg(dis_pkg::OFS_PENDING, v);
        chk("sticky", 32'h4, v);
        rd_reg(dis_pkg::OFS_LEVELS, v);
        chk("levels", 32'h18, v);
        $display("test mask done");
    endtask

    // clock enable low: writes and events are ignored, the line holds
    task automatic t_freeze();
        logic [31:0] v;
        @(posedge clock_i);
        ce <= 1'b0;
        wr_reg(dis_pkg::OFS_ENABLE, 32'h00000004);
        fire(8);
        chk("frozen line", 32'h1, {31'h0, inta_n});
        ce <= 1'b1;
        rd_reg(dis_pkg::OFS_ENABLE, v);
        chk("frozen enable", 32'h0, v);
        rd_reg(dis_pkg::OFS_PENDING, v);
        chk("frozen pending", 32'h4, v);
        $display("test freeze done");
    endtask

    // --------------------------------------------------------------
    // main sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clock_i);
        resetn_i <= 1'b1;
        t_reset();
        t_sources();
        t_refuse();
        t_mask();
        t_freeze();
        final_report();
    end

    initial begin
        repeat (50000) @(posedge clock_i);
        n_mismatch++;
        final_report();
    end
endmodule // dis_top_test

`default_nettype wire
